/* File: adc_model.sv */
// Purpose: behavioural converter that answers the scale's start pulse
// Assumes: start pulse and pins are sampled on the rising clock edge
// Notes: data toggles while busy, since a converter mid-cycle holds no valid code

`timescale 1ns/10ps

module adc_model
(
  // clock
  input wire logic i_clock,
  // control from the bench and the scale
  input wire logic i_start,
  input wire logic [6:0] i_code,
  input wire logic [15:0] i_conv_len,
  // converter pins
  output logic o_busy,
  output logic [6:0] o_data
);
  // every pin starts from a known level at time zero
  logic start_d_r = 1'b0;
  logic [15:0] wait_r = 16'h0000;
  logic [15:0] left_r = 16'h0000;
  logic [6:0] code_r = 7'h00;
  logic busy_r = 1'b0;
  logic [6:0] data_r = 7'h00;

  // ---------------------------------------------------------------
  // conversion sequence
  // ---------------------------------------------------------------
  // a conversion begins only on the rising start pulse, length set by the bench
  always @(posedge i_clock)
  begin
    start_d_r <= i_start;
    if (i_start && !start_d_r)
    begin
      code_r <= i_code;
      wait_r <= 16'h0008;
    end
    else if (wait_r != 16'h0000)
    begin
      wait_r <= wait_r - 16'h0001;
      if (wait_r == 16'h0001)
      begin
        busy_r <= 1'b1;
        left_r <= i_conv_len;
      end
    end
    else if (busy_r)
    begin
      left_r <= left_r - 16'h0001;
      if (left_r == 16'h0001)
      begin
        busy_r <= 1'b0;
        data_r <= code_r;
      end
      else
        data_r <= ~data_r; // no settled code while converting
    end
  end

  // pins show the model's state; the code stays put while the strobe is low
  assign o_busy = busy_r;
  assign o_data = data_r;
endmodule

/* File: lamp_decoder.sv */
// Purpose: binary to one-of-n lamp driver select with over-range clamp
// Assumes: value and enable come from logic on the same clock
// Notes: lamp selection is registered, one cycle after the value

`timescale 1ns/10ps

module lamp_decoder
  import scale_display_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // selection link
  lamp_select_if.dec sel
);

  // ---------------------------------------------------------------
  // clamp and one-hot decode
  // ---------------------------------------------------------------

  // anything past the top count shows as the last lamp
  function automatic logic [DATA_W-1:0] clamp_code(input logic [DATA_W-1:0] code);
    clamp_code = (code > TOP_COUNT) ? TOP_COUNT : code;
  endfunction

  logic [DATA_W-1:0] code_clamped;
  logic [LAMP_N-1:0] hot;
  logic [LAMP_N-1:0] lamps_r;
  logic [LAMP_N-1:0] lamps_nxt;

  assign code_clamped = clamp_code(sel.value);

  // one comparator per lamp position
  generate
    for (genvar i = 0; i < LAMP_N; i++)
    begin : g_pos
      assign hot[i] = (code_clamped == DATA_W'(i));
    end
  endgenerate

  // blanked while the converter is busy
  assign lamps_nxt = sel.enable ? hot : '0;

  // ---------------------------------------------------------------
  // lamp register
  // ---------------------------------------------------------------

  // each bit drives one driver, which lights a pair of lamps
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      lamps_r <= '0;
    else
      lamps_r <= lamps_nxt;
  end

  assign sel.lamps = lamps_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  a_clamp_top: assert property (@(posedge i_clock) disable iff (!i_rstn)
    sel.enable && (sel.value >= TOP_COUNT) |=> lamps_r[LAMP_N-1] && $onehot(lamps_r))
    else $error("over-range value did not select the last lamp");

  a_decode_exact: assert property (@(posedge i_clock) disable iff (!i_rstn)
    sel.enable && (sel.value < TOP_COUNT) |=> lamps_r[$past(sel.value)] && $onehot(lamps_r))
    else $error("lamp does not match the decoded value");

  c_clamp: cover property (@(posedge i_clock) disable iff (!i_rstn)
    sel.enable && (sel.value > TOP_COUNT));

endmodule

/* File: lamp_select_if.sv */
// Purpose: carries the value to show and the decoder's lamp selection
// Assumes: one clock domain
// Notes: driven by the scale control, answered by the lamp decoder

`timescale 1ns/10ps

interface lamp_select_if;
  import scale_display_pkg::*;

  logic [DATA_W-1:0] value;
  logic enable;
  logic [LAMP_N-1:0] lamps;

  // control side drives the value, decoder side drives the lamps
  modport ctrl (output value, output enable, input lamps);
  modport dec (input value, input enable, output lamps);
endinterface

/* File: scale_display_pkg.sv */
// Purpose: shared constants and types for the pointer scale display logic
// Assumes: 125 MHz system clock, 7-bit converter code
// Notes: long counts are derived here and overridden as top parameters

package scale_display_pkg;

  // ---------------------------------------------------------------
  // data widths and scale limits
  // ---------------------------------------------------------------
  localparam int DATA_W = 7;
  localparam int LAMP_N = 100;
  localparam logic [6:0] TOP_COUNT = 7'h63;
  localparam logic [6:0] ZERO_COUNT = 7'h00;
  localparam logic [6:0] PLUS_ONE = 7'h01;
  localparam logic [6:0] MINUS_ONE = 7'h7f;

  // ---------------------------------------------------------------
  // timing, each figure in its own unit, then in clock cycles
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int START_PULSE_US = 1;
  localparam int START_PULSE_CYC = START_PULSE_US * CLK_MHZ;
  localparam int TRIG_PERIOD_MS = 7;
  localparam int TRIG_PERIOD_CYC = TRIG_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int GATE_LOW_MS = 2;
  localparam int GATE_LOW_CYC = GATE_LOW_MS * 1000 * CLK_MHZ;
  localparam int TREND_ON_US = 1000;
  localparam int TREND_ON_CYC = TREND_ON_US * CLK_MHZ;
  localparam int CNT_W = 20;

  // scale flavour: only some scales carry the trend lamp
  typedef enum {SCALE_POINTER_ONLY, SCALE_WITH_TREND} scale_kind_t;

endpackage

/* File: scale_pointer_trend_display.sv */
// Purpose: conversion trigger, blanking, trend detection and lamp select
//          for one illuminated pointer scale
// Assumes: external converter holds its strobe high while converting and
//          keeps its data stable once the strobe is low
// Notes: long counts are parameters so a simulation can shorten them
//        the trend lamp replaces the pointer in the last slice of each period
//        the top end is clamped in the decoder, the bottom end here

`timescale 1ns/10ps

module scale_pointer_trend_display
  import scale_display_pkg::*;
#(
  parameter scale_kind_t KIND = SCALE_WITH_TREND,
  parameter int PERIOD_CYC = TRIG_PERIOD_CYC,
  parameter int LOW_CYC = GATE_LOW_CYC,
  parameter int TREND_CYC = TREND_ON_CYC
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // converter side
  input wire logic [DATA_W-1:0] i_adc_data,
  input wire logic i_adc_busy,
  output logic o_conv_start,
  // lamp drivers
  output logic [LAMP_N-1:0] o_lamp,
  // trend status
  output logic o_trend_up,
  output logic o_trend_valid
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------

  logic [DATA_W-1:0] data_s1_r;
  logic [DATA_W-1:0] data_s2_r;
  logic busy_s1_r;
  logic busy_s2_r;
  logic busy_s3_r;

  // converter pins are asynchronous to our clock
  // the data word needs no gray code: it is only taken once the strobe has
  // been low for a full synchroniser delay, when every bit has settled
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      data_s1_r <= '0;
      data_s2_r <= '0;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      busy_s3_r <= 1'b0;
    end
    else
    begin
      data_s1_r <= i_adc_data;
      data_s2_r <= data_s1_r;
      busy_s1_r <= i_adc_busy;
      busy_s2_r <= busy_s1_r;
      busy_s3_r <= busy_s2_r;
    end
  end

  // ---------------------------------------------------------------
  // period timer and start pulse
  // ---------------------------------------------------------------

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic period_end;
  logic start_r;
  logic start_nxt;
  logic gate_high;
  logic trend_phase;

  // free-running period counter, wraps once per trigger period
  assign period_end = (cnt_r == CNT_W'(PERIOD_CYC - 1));
  assign cnt_nxt = period_end ? '0 : cnt_r + CNT_W'(1);
  assign start_nxt = (cnt_nxt < CNT_W'(START_PULSE_CYC));
  // low interval opens each period, so the new conversion settles first
  assign gate_high = (cnt_r >= CNT_W'(LOW_CYC));
  // trend lamp shown in the last slice of the period; slice width sets brightness
  assign trend_phase = (cnt_r >= CNT_W'(PERIOD_CYC - TREND_CYC));

  // one counter gives the start pulse, the comparator gate and the trend slice
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      // park on the last count so the first pulse after reset is full width
      cnt_r <= CNT_W'(PERIOD_CYC - 1);
      start_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      start_r <= start_nxt;
    end
  end

  assign o_conv_start = start_r;

  // ---------------------------------------------------------------
  // live data latch and stored sample
  // ---------------------------------------------------------------

  logic busy_fell;
  logic [DATA_W-1:0] live_r;
  logic [DATA_W-1:0] stored_r;
  logic have_data_r;

  // data is only trusted once the strobe has dropped
  assign busy_fell = busy_s3_r && !busy_s2_r;

  // the stored copy is taken at period end, so each period compares against
  // the code that was shown during the one before
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      live_r <= '0;
      stored_r <= '0;
      have_data_r <= 1'b0;
    end
    else
    begin
      if (busy_fell)
        live_r <= data_s2_r;
      if (busy_fell)
        have_data_r <= 1'b1;
      if (period_end)
        stored_r <= live_r;
    end
  end

  // ---------------------------------------------------------------
  // trend comparator and direction flip-flop
  // ---------------------------------------------------------------

  logic trend_present;
  logic live_below;
  logic live_above;
  logic dir_up_r;
  logic dir_up_nxt;
  logic dir_valid_r;
  logic dir_valid_nxt;

  assign trend_present = (KIND == SCALE_WITH_TREND);
  // both outputs forced off during the low interval
  assign live_below = trend_present && gate_high && (live_r < stored_r);
  assign live_above = trend_present && gate_high && (live_r > stored_r);
  // equal values raise neither, so the direction holds
  assign dir_up_nxt = live_above ? 1'b1 : (live_below ? 1'b0 : dir_up_r);
  assign dir_valid_nxt = dir_valid_r || live_above || live_below;

  // direction and its valid flag move only on the gated comparator outputs
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      dir_up_r <= 1'b0;
      dir_valid_r <= 1'b0;
    end
    else
    begin
      dir_up_r <= dir_up_nxt;
      dir_valid_r <= dir_valid_nxt;
    end
  end

  assign o_trend_up = dir_up_r;
  assign o_trend_valid = dir_valid_r;

  // ---------------------------------------------------------------
  // plus or minus one adder and decoder feed
  // ---------------------------------------------------------------

  logic trend_on;
  logic at_floor;
  logic [DATA_W-1:0] addend;
  logic [DATA_W-1:0] offset_sum;
  logic [DATA_W-1:0] disp_value;

  lamp_select_if sel ();

  // rising shows the lamp behind, falling shows it ahead
  assign addend = dir_up_r ? MINUS_ONE : PLUS_ONE;
  assign offset_sum = live_r + addend;
  // no wrap below zero; the top side is clamped by the decoder
  assign at_floor = dir_up_r && (live_r == ZERO_COUNT);
  assign trend_on = trend_present && dir_valid_r && trend_phase && !at_floor;
  assign disp_value = trend_on ? offset_sum : live_r;
  assign sel.value = disp_value;
  // decoder held off for the whole conversion, a small share of the period;
  // also off in the cycle the new code is latched, so no stale value flashes
  assign sel.enable = !(busy_s2_r || busy_s3_r) && have_data_r;

  lamp_decoder u_decoder (
    .i_clock (i_clock),
    .i_rstn (i_rstn),
    .sel (sel)
  );

  assign o_lamp = sel.lamps;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  localparam int PULSE_W = START_PULSE_CYC;
  logic [CNT_W-1:0] pulse_len_r;

  // counts the high cycles of the start pulse
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      pulse_len_r <= '0;
    else if (start_nxt && !start_r)
      pulse_len_r <= CNT_W'(1);
    else if (start_nxt)
      pulse_len_r <= pulse_len_r + CNT_W'(1);
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  a_start_origin: assert property ($rose(start_r) |-> cnt_r == '0)
    else $error("start pulse not aligned with the period start");

  a_start_width: assert property ($fell(start_r) |-> pulse_len_r == CNT_W'(PULSE_W))
    else $error("start pulse width is wrong");

  a_busy_blanks: assert property (busy_s2_r |=> o_lamp == '0)
    else $error("lamps lit while converter busy");

  a_ready_shows: assert property (busy_fell |-> ##[1:2] $onehot(o_lamp))
    else $error("decoder not enabled after conversion end");

  a_lamp_onehot: assert property (|o_lamp |-> $onehot(o_lamp))
    else $error("more than one lamp driver enabled");

  a_low_holds_dir: assert property (!gate_high |=> $stable(dir_up_r))
    else $error("direction changed in the low interval");

  a_equal_keeps: assert property (gate_high && live_r == stored_r |=> $stable(dir_up_r))
    else $error("direction changed on equal data");

  a_rise_sets_dir: assert property (live_above |=> dir_up_r && dir_valid_r)
    else $error("rising data did not set the direction");

  a_fall_clears: assert property (live_below |=> !dir_up_r && dir_valid_r)
    else $error("falling data did not clear the direction");

  a_trend_side: assert property (trend_on && dir_up_r |-> disp_value == live_r - PLUS_ONE)
    else $error("trend lamp not behind a rising pointer");

  a_plain_scale: assert property (!trend_present |-> disp_value == live_r && !dir_valid_r)
    else $error("trend offset on a pointer-only scale");

  // internal checks on the latch, the stored copy, the gate and the adder
  a_live_latch: assert property (busy_fell |=> live_r == $past(data_s2_r))
    else $error("converter code not latched at the end of conversion");

  a_stored_copy: assert property (period_end |=> stored_r == $past(live_r))
    else $error("stored sample not refreshed at period end");

  a_low_no_compare: assert property (!gate_high |-> !live_above && !live_below)
    else $error("comparator active in the low interval");

  a_slice_only: assert property (!trend_phase |-> disp_value == live_r)
    else $error("offset applied outside the trend slice");

  a_trend_ahead: assert property (trend_on && !dir_up_r |->
    disp_value == live_r + PLUS_ONE)
    else $error("trend lamp not ahead of a falling pointer");

  a_floor_no_wrap: assert property (dir_up_r && live_r == ZERO_COUNT |->
    disp_value == ZERO_COUNT)
    else $error("trend offset wrapped below the first position");

  c_conversion: cover property ($rose(start_r) ##[1:300] busy_fell);
  c_trend_up: cover property (trend_on && dir_up_r);
  c_trend_down: cover property (trend_on && !dir_up_r);
  c_equal_hold: cover property (gate_high && trend_present && dir_up_r && live_r == stored_r);

endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench for one pointer scale with and without trend
// Assumes: shortened period 2000, low interval 500, trend slice 400 cycles
// Notes: samples are taken at fixed offsets from each start pulse

`timescale 1ns/10ps

module tb_top
  import scale_display_pkg::*;
;
  logic i_clock;
  logic i_rstn;
  logic [6:0] code;
  logic [15:0] conv_len;
  logic [DATA_W-1:0] adc_data;
  logic adc_busy;
  logic conv_start;
  logic [LAMP_N-1:0] lamp;
  logic trend_up;
  logic trend_valid;
  logic [LAMP_N-1:0] lamp_plain;
  logic valid_plain;
  logic [LAMP_N-1:0] s_blank, s_mid, s_slice, p_slice;
  logic s_up_early, s_up_mid, s_valid;
  int miscompares;
  int checks_done;

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  // trend scale takes the default kind
  scale_pointer_trend_display #(.PERIOD_CYC(2000), .LOW_CYC(500), .TREND_CYC(400)) dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_adc_data(adc_data),
    .i_adc_busy(adc_busy), .o_conv_start(conv_start), .o_lamp(lamp),
    .o_trend_up(trend_up), .o_trend_valid(trend_valid));
  // plain scale shares the converter and period; it has no gate or trend slice to use
  scale_pointer_trend_display #(.KIND(SCALE_POINTER_ONLY), .PERIOD_CYC(2000)) dut_plain (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_adc_data(adc_data),
    .i_adc_busy(adc_busy), .o_conv_start(), .o_lamp(lamp_plain),
    .o_trend_up(), .o_trend_valid(valid_plain));
  adc_model converter (.i_clock(i_clock), .i_start(conv_start), .i_code(code),
    .i_conv_len(conv_len), .o_busy(adc_busy), .o_data(adc_data));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [LAMP_N-1:0] onehot(input int k);
    onehot = '0;
    onehot[k] = 1'b1;
  endfunction

  task automatic check(input logic [LAMP_N-1:0] seen, input logic [LAMP_N-1:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // one display period: blank, low interval, compare window, trend slice
  task automatic run_period(input logic [6:0] c);
    int n;
    @(posedge i_clock);
    code <= c;
    #1;
    n = 0;
    while (conv_start !== 1'b1 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    cyc(20);
    s_blank = lamp;
    cyc(280);
    s_up_early = trend_up;
    cyc(700);
    s_mid = lamp;
    s_up_mid = trend_up;
    s_valid = trend_valid;
    cyc(800);
    s_slice = lamp;
    p_slice = lamp_plain;
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic first_value();
    check(lamp, '0);
    run_period(7'h28);
    check(s_blank, '0);
    check(s_mid, onehot(40));
    check(p_slice, onehot(40));
  endtask

  task automatic rising();
    run_period(7'h32);
    check(s_mid, onehot(50));
    check(LAMP_N'(s_up_mid), LAMP_N'(1'b1));
    check(LAMP_N'(s_valid), LAMP_N'(1'b1));
    check(s_slice, onehot(49));
    check(p_slice, onehot(50));
    check(LAMP_N'(valid_plain), '0);
  endtask

  task automatic falling_low();
    run_period(7'h1e);
    check(LAMP_N'(s_up_early), LAMP_N'(1'b1));
    check(LAMP_N'(s_up_mid), '0);
    check(s_mid, onehot(30));
    check(s_slice, onehot(31));
  endtask

  task automatic equal_slow();
    @(posedge i_clock);
    conv_len <= 16'h0078; // slow converter answer
    run_period(7'h1e);
    check(s_blank, '0);
    check(LAMP_N'(s_up_mid), '0);
    check(s_slice, onehot(31));
    @(posedge i_clock);
    conv_len <= 16'h0018;
  endtask

  task automatic clamp_then_bottom();
    run_period(7'h78);
    check(s_mid, onehot(99));
    check(LAMP_N'(s_up_mid), LAMP_N'(1'b1));
    run_period(7'h78);
    check(LAMP_N'(s_up_mid), LAMP_N'(1'b1));
    check(s_slice, onehot(99));
    run_period(7'h00);
    check(s_mid, onehot(0));
    check(s_slice, onehot(1));
  endtask

  task automatic start_timing();
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    while (conv_start !== 1'b1 && lo < 3000)
    begin
      cyc(1);
      lo++;
    end
    while (conv_start === 1'b1 && hi < 3000)
    begin
      cyc(1);
      hi++;
    end
    lo = 0;
    while (conv_start !== 1'b1 && lo < 3000)
    begin
      cyc(1);
      lo++;
    end
    check(LAMP_N'(hi), LAMP_N'(START_PULSE_CYC));
    check(LAMP_N'(hi + lo), LAMP_N'(2000));
  endtask

  // ---------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  initial
  begin
    i_rstn = 1'b0;
    code = 7'h28;
    conv_len = 16'h0018;
    miscompares = 0;
    checks_done = 0;
    repeat (4) @(posedge i_clock);
    i_rstn <= 1'b1;
    #1;
    first_value();
    rising();
    falling_low();
    equal_slow();
    clamp_then_bottom();
    start_timing();
    stop_test();
  end

  // about eight periods are needed; allow well over twice that
  initial
  begin
    #(50000 * 8);
    miscompares++;
    stop_test();
  end
endmodule
